//--- verilog/csd_pkg.sv
// Operation
// - Each select runs 8, 16 or 32 bits.
// - Address aligned to byte, halfword or word.
// - 8-bit data rides on D31 to D24.
// - 16-bit data rides on D31 to D16.
// - 32-bit data uses the whole bus.
// - External address bus is 28 bits wide.
// - Top two lines are address only when enabled.
// - Address arranged by width and memory type.
// - Five active-low select outputs.
// - Five register sets, only zero with a wait count; zero self-configures.
// - DRAM select acts as row strobe.
// - Only address bits 31 to 12 compared.
// - Mask one compares, mask zero ignores.
// - Window is at least 4096 bytes.
// - Match when masked address equals masked base.
// - Base bits under zero mask ignored.
// - Gapped masks alias the device repeatedly.
// - Contiguous masks give power-of-two windows.
// - Select zero configured automatically at power-up.
// - Straps on A24 and A23 set select zero.
// - Select decodes only while valid is set.
package csd_pkg;

  localparam int CSD_NUM_SEL = 5;
  localparam int CSD_ADDR_W = 28;
  localparam int CSD_MASK_W = 20;
  localparam int CSD_MASK_LSB = 12;
  localparam int CSD_COL_BITS = 10;

  localparam logic [1:0] CSD_PW_32 = 2'h0;
  localparam logic [1:0] CSD_PW_16 = 2'h1;
  localparam logic [1:0] CSD_PW_8 = 2'h2;
  localparam logic [1:0] CSD_PW_32X = 2'h3;

  localparam logic [1:0] CSD_SHIFT_8 = 2'h0;
  localparam logic [1:0] CSD_SHIFT_16 = 2'h1;
  localparam logic [1:0] CSD_SHIFT_32 = 2'h2;

  localparam logic [3:0] CSD_LANES_8 = 4'h8;
  localparam logic [3:0] CSD_LANES_16 = 4'hC;
  localparam logic [3:0] CSD_LANES_32 = 4'hF;

  localparam logic [1:0] CSD_BOOT_OFF = 2'h0;
  localparam logic [1:0] CSD_BOOT_SRAM32 = 2'h1;
  localparam logic [1:0] CSD_BOOT_DRAM32 = 2'h2;
  localparam logic [1:0] CSD_BOOT_SRAM16 = 2'h3;
  localparam logic [3:0] CSD_BOOT_WAIT = 4'hF;

  localparam logic [19:0] CSD_MASK_RST = 20'h00000;
  localparam logic [19:0] CSD_BASE_RST = 20'h00000;
  localparam logic [3:0] CSD_WAIT_RST = 4'h0;
  localparam logic [27:0] CSD_ADDR_RST = 28'h0000000;
  localparam logic [31:0] CSD_DATA_RST = 32'h00000000;
  localparam logic [4:0] CSD_SEL_IDLE = 5'h1F;

endpackage : csd_pkg

//--- verilog/csd_window_match.sv
`timescale 1ns/1ps
`default_nettype none
module csd_window_match
  import csd_pkg::*;
(
  input wire logic [31:0] addr_i,
  input wire logic [CSD_MASK_W-1:0] base_i,
  input wire logic [CSD_MASK_W-1:0] mask_i,
  input wire logic valid_i,
  output logic hit_o
);

  // Only the upper twenty bits take part; masked base bits are ignored.
  assign hit_o = valid_i && ((addr_i[31:CSD_MASK_LSB] & mask_i) == (base_i & mask_i));

endmodule : csd_window_match
`default_nettype wire

//--- verilog/csd_top.sv
`timescale 1ns/1ps
`default_nettype none
module csd_top
  import csd_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [1:0] boot_strap_i,
  input wire logic cfg_we_i,
  input wire logic [2:0] cfg_idx_i,
  input wire logic [CSD_MASK_W-1:0] cfg_base_i,
  input wire logic [CSD_MASK_W-1:0] cfg_mask_i,
  input wire logic [1:0] cfg_port_width_field_i,
  input wire logic cfg_dynamic_select_field_i,
  input wire logic [3:0] cfg_wait_i,
  input wire logic cfg_select_valid_bit_i,
  input wire logic memcfg_we_i,
  input wire logic memcfg_upper_addr27_enable_i,
  input wire logic memcfg_upper_addr26_enable_i,
  input wire logic req_valid_i,
  input wire logic req_wr_i,
  input wire logic [31:0] req_addr_i,
  input wire logic [31:0] req_wdata_i,
  input wire logic [31:0] data_i,
  output logic [CSD_NUM_SEL-1:0] select_or_row_strobe_n_o,
  output logic [CSD_ADDR_W-1:0] ext_addr_o,
  output logic upper_addr_alt_fn_o,
  output logic [31:0] data_o,
  output logic [3:0] data_lane_oe_o,
  output logic rd_valid_o,
  output logic [31:0] rd_data_o,
  output logic miss_o,
  output logic [3:0] sel0_wait_o,
  output logic boot_done_o
);

  // ----------------------------------------------------------------
  // Configuration state
  // ----------------------------------------------------------------
  logic [CSD_MASK_W-1:0] base_reg [CSD_NUM_SEL];
  logic [CSD_MASK_W-1:0] base_next [CSD_NUM_SEL];
  logic [CSD_MASK_W-1:0] mask_reg [CSD_NUM_SEL];
  logic [CSD_MASK_W-1:0] mask_next [CSD_NUM_SEL];
  logic [1:0] width_reg [CSD_NUM_SEL];
  logic [1:0] width_next [CSD_NUM_SEL];
  logic [CSD_NUM_SEL-1:0] dyn_reg;
  logic [CSD_NUM_SEL-1:0] dyn_next;
  logic [CSD_NUM_SEL-1:0] valid_reg;
  logic [CSD_NUM_SEL-1:0] valid_next;
  logic [3:0] wait0_reg;
  logic [3:0] wait0_next;
  logic alt_fn_reg;
  logic alt_fn_next;
  logic boot_done_reg;
  logic boot_done_next;

  always_comb begin
    for (int i = 0; i < CSD_NUM_SEL; i++) begin
      base_next[i] = base_reg[i];
      mask_next[i] = mask_reg[i];
      width_next[i] = width_reg[i];
      dyn_next[i] = dyn_reg[i];
      valid_next[i] = valid_reg[i];
      if (cfg_we_i && (cfg_idx_i == 3'(i))) begin
        base_next[i] = cfg_base_i;
        mask_next[i] = cfg_mask_i;
        width_next[i] = cfg_port_width_field_i;
        dyn_next[i] = cfg_dynamic_select_field_i;
        valid_next[i] = cfg_select_valid_bit_i;
      end
    end
    wait0_next = wait0_reg;
    if (cfg_we_i && (cfg_idx_i == 3'h0)) begin
      wait0_next = cfg_wait_i;
    end
    alt_fn_next = alt_fn_reg;
    if (memcfg_we_i) begin
      alt_fn_next = !(memcfg_upper_addr27_enable_i && memcfg_upper_addr26_enable_i);
    end
    boot_done_next = 1'b1;
    // Straps are caught in the first cycle after reset release.
    if (!boot_done_reg) begin
      base_next[0] = CSD_BASE_RST;
      mask_next[0] = CSD_MASK_RST;
      dyn_next[0] = (boot_strap_i == CSD_BOOT_DRAM32);
      valid_next[0] = (boot_strap_i != CSD_BOOT_OFF);
      wait0_next = (boot_strap_i == CSD_BOOT_OFF) ? CSD_WAIT_RST : CSD_BOOT_WAIT;
      width_next[0] = (boot_strap_i == CSD_BOOT_SRAM16) ? CSD_PW_16 : CSD_PW_32;
      alt_fn_next = (boot_strap_i == CSD_BOOT_SRAM16);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < CSD_NUM_SEL; i++) begin
        base_reg[i] <= CSD_BASE_RST;
        mask_reg[i] <= CSD_MASK_RST;
        width_reg[i] <= CSD_PW_32;
      end
      dyn_reg <= '0;
      valid_reg <= '0;
      wait0_reg <= CSD_WAIT_RST;
      alt_fn_reg <= 1'b0;
      boot_done_reg <= 1'b0;
    end else begin
      base_reg <= base_next;
      mask_reg <= mask_next;
      width_reg <= width_next;
      dyn_reg <= dyn_next;
      valid_reg <= valid_next;
      wait0_reg <= wait0_next;
      alt_fn_reg <= alt_fn_next;
      boot_done_reg <= boot_done_next;
    end
  end

  // ----------------------------------------------------------------
  // Window decode
  // ----------------------------------------------------------------
  logic [CSD_NUM_SEL-1:0] hit_vec;
  logic [CSD_NUM_SEL-1:0] win_vec;

  for (genvar g = 0; g < CSD_NUM_SEL; g++) begin : g_win
    csd_window_match u_match (
      .addr_i(req_addr_i),
      .base_i(base_reg[g]),
      .mask_i(mask_reg[g]),
      .valid_i(valid_reg[g]),
      .hit_o(hit_vec[g])
    );
  end

  // Lowest-numbered hit is isolated so the selects never overlap.
  assign win_vec = hit_vec & (~hit_vec + 5'h01);

  // ----------------------------------------------------------------
  // Access path
  // ----------------------------------------------------------------
  logic [CSD_NUM_SEL-1:0] sel_n_reg;
  logic [CSD_NUM_SEL-1:0] sel_n_next;
  logic [CSD_ADDR_W-1:0] addr_reg;
  logic [CSD_ADDR_W-1:0] addr_next;
  logic [31:0] dout_reg;
  logic [31:0] dout_next;
  logic [3:0] oe_reg;
  logic [3:0] oe_next;
  logic miss_reg;
  logic miss_next;
  logic rd_pend_reg;
  logic rd_pend_next;
  logic [1:0] rd_width_reg;
  logic [1:0] rd_width_next;
  logic rd_valid_reg;
  logic rd_valid_next;
  logic [31:0] rd_data_reg;
  logic [31:0] rd_data_next;
  logic [1:0] win_width;
  logic win_dyn;
  logic [1:0] lane_shift;
  logic [31:0] arranged;

  always_comb begin
    win_width = CSD_PW_32;
    win_dyn = 1'b0;
    for (int i = CSD_NUM_SEL - 1; i >= 0; i--) begin
      if (win_vec[i]) begin
        win_width = width_reg[i];
        win_dyn = dyn_reg[i];
      end
    end
    unique case (win_width)
      CSD_PW_8: lane_shift = CSD_SHIFT_8;
      CSD_PW_16: lane_shift = CSD_SHIFT_16;
      CSD_PW_32, CSD_PW_32X: lane_shift = CSD_SHIFT_32;
    endcase
    // Static parts see the aligned address; DRAM parts see the row part.
    if (win_dyn) begin
      arranged = ((req_addr_i >> (32'(lane_shift) + CSD_COL_BITS)) << lane_shift);
    end else begin
      arranged = (req_addr_i >> lane_shift) << lane_shift;
    end
    sel_n_next = CSD_SEL_IDLE;
    addr_next = addr_reg;
    dout_next = dout_reg;
    oe_next = 4'h0;
    miss_next = 1'b0;
    rd_pend_next = 1'b0;
    rd_width_next = rd_width_reg;
    if (req_valid_i) begin
      miss_next = (win_vec == '0);
      if (win_vec != '0) begin
        sel_n_next = ~win_vec;
        addr_next = arranged[CSD_ADDR_W-1:0];
        if (alt_fn_reg) begin
          addr_next[CSD_ADDR_W-1 -: 2] = 2'h0;
        end
        rd_pend_next = !req_wr_i;
        rd_width_next = win_width;
        if (req_wr_i) begin
          unique case (win_width)
            CSD_PW_8: begin
              dout_next = {req_wdata_i[7:0], 24'h000000};
              oe_next = CSD_LANES_8;
            end
            CSD_PW_16: begin
              dout_next = {req_wdata_i[15:0], 16'h0000};
              oe_next = CSD_LANES_16;
            end
            CSD_PW_32, CSD_PW_32X: begin
              dout_next = req_wdata_i;
              oe_next = CSD_LANES_32;
            end
          endcase
        end
      end
    end
    rd_valid_next = rd_pend_reg;
    rd_data_next = rd_data_reg;
    if (rd_pend_reg) begin
      unique case (rd_width_reg)
        CSD_PW_8: rd_data_next = {24'h000000, data_i[31:24]};
        CSD_PW_16: rd_data_next = {16'h0000, data_i[31:16]};
        CSD_PW_32, CSD_PW_32X: rd_data_next = data_i;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sel_n_reg <= CSD_SEL_IDLE;
      addr_reg <= CSD_ADDR_RST;
      dout_reg <= CSD_DATA_RST;
      oe_reg <= 4'h0;
      miss_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      rd_width_reg <= CSD_PW_32;
      rd_valid_reg <= 1'b0;
      rd_data_reg <= CSD_DATA_RST;
    end else begin
      sel_n_reg <= sel_n_next;
      addr_reg <= addr_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      miss_reg <= miss_next;
      rd_pend_reg <= rd_pend_next;
      rd_width_reg <= rd_width_next;
      rd_valid_reg <= rd_valid_next;
      rd_data_reg <= rd_data_next;
    end
  end

  assign select_or_row_strobe_n_o = sel_n_reg;
  assign ext_addr_o = addr_reg;
  assign upper_addr_alt_fn_o = alt_fn_reg;
  assign data_o = dout_reg;
  assign data_lane_oe_o = oe_reg;
  assign rd_valid_o = rd_valid_reg;
  assign rd_data_o = rd_data_reg;
  assign miss_o = miss_reg;
  assign sel0_wait_o = wait0_reg;
  assign boot_done_o = boot_done_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  property p_onehot;
    $onehot0(~select_or_row_strobe_n_o);
  endproperty
  a_onehot: assert property (p_onehot) else $error("Two selects low at once.");

  property p_valid_gate;
    !select_or_row_strobe_n_o[1] |-> $past(valid_reg[1]);
  endproperty
  a_valid_gate: assert property (p_valid_gate) else $error("Disabled select drove.");

  property p_match0;
    req_valid_i && valid_reg[0] && ((req_addr_i[31:12] & mask_reg[0]) == (base_reg[0] & mask_reg[0]))
      |=> !select_or_row_strobe_n_o[0];
  endproperty
  a_match0: assert property (p_match0) else $error("Matching select zero not driven.");

  property p_lane8;
    req_valid_i && req_wr_i && (win_width == CSD_PW_8) && (win_vec != '0)
      |=> (data_lane_oe_o == CSD_LANES_8) && (data_o[31:24] == $past(req_wdata_i[7:0]));
  endproperty
  a_lane8: assert property (p_lane8) else $error("Byte port lane wrong.");

  property p_lane16;
    req_valid_i && req_wr_i && (win_width == CSD_PW_16) && (win_vec != '0)
      |=> (data_lane_oe_o == CSD_LANES_16) && (data_o[31:16] == $past(req_wdata_i[15:0]));
  endproperty
  a_lane16: assert property (p_lane16) else $error("Halfword port lane wrong.");

  property p_align32;
    req_valid_i && !win_dyn && (win_width == CSD_PW_32) && (win_vec != '0)
      |=> (ext_addr_o[1:0] == 2'h0) && (ext_addr_o[25:2] == $past(req_addr_i[25:2]));
  endproperty
  a_align32: assert property (p_align32) else $error("Word address wrong.");

  property p_upper;
    (select_or_row_strobe_n_o != CSD_SEL_IDLE) && $past(upper_addr_alt_fn_o)
      |-> ext_addr_o[27:26] == 2'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("Upper lines driven as address.");

  property p_boot;
    $rose(boot_done_o) ##0 ($past(boot_strap_i) == CSD_BOOT_SRAM16)
      |-> valid_reg[0] && (width_reg[0] == CSD_PW_16) && upper_addr_alt_fn_o
        && (sel0_wait_o == CSD_BOOT_WAIT);
  endproperty
  a_boot: assert property (p_boot) else $error("Boot strap setup wrong.");

  property p_read;
    req_valid_i && !req_wr_i && (win_vec != '0) |=> ##1 rd_valid_o;
  endproperty
  a_read: assert property (p_read) else $error("Read return missing.");

  c_miss: cover property (req_valid_i ##1 miss_o);
  c_byte_read: cover property (req_valid_i && !req_wr_i && win_width == CSD_PW_8 ##2 rd_valid_o);
  c_dram: cover property (req_valid_i && win_dyn && win_vec != '0);
  c_multi: cover property (req_valid_i && !$onehot0(hit_vec));

endmodule : csd_top
`default_nettype wire

//--- bench/csd_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module csd_mem_model
  import csd_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic [CSD_NUM_SEL-1:0] select_or_row_strobe_n_i,
  input wire logic [CSD_ADDR_W-1:0] ext_addr_i,
  input wire logic [31:0] data_i,
  input wire logic [3:0] data_lane_oe_i,
  output var logic [31:0] data_o
);
  // ----------------------------------------
  // Memory behind the selects.
  // ----------------------------------------
  logic [31:0] mem [logic [32:0]];
  logic [32:0] key;
  assign key = {select_or_row_strobe_n_i, ext_addr_i};
  initial data_o = 32'h00000000;
  // Writes are stored per select and address; an idle bus shows the inverse of its last value.
  always @(negedge core_clk_i) begin
    if (select_or_row_strobe_n_i != CSD_SEL_IDLE && data_lane_oe_i != 4'h0) begin
      mem[key] = data_i;
    end
    if (select_or_row_strobe_n_i != CSD_SEL_IDLE && mem.exists(key)) begin
      data_o <= mem[key];
    end else begin
      data_o <= ~data_o;
    end
  end
endmodule : csd_mem_model
`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import csd_pkg::*;
;
  // ----------------------------------------
  // Stimulus and scoreboard.
  // ----------------------------------------
  typedef struct {
    logic [4:0] sel;
    logic [27:0] addr;
    logic [3:0] oe;
    logic [31:0] dat;
    logic [31:0] rd;
    logic miss;
  } csd_exp_s;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [1:0] strap = 2'h1;
  logic cfg_we = 1'b0;
  logic memcfg_we = 1'b0;
  logic req_v = 1'b0;
  logic req_wr = 1'b0;
  logic [2:0] cfg_idx = 3'h0;
  logic [19:0] cfg_base = 20'h00000;
  logic [19:0] cfg_mask = 20'h00000;
  logic [1:0] cfg_pw = 2'h0;
  logic cfg_dr = 1'b0;
  logic [3:0] cfg_wait = 4'h0;
  logic cfg_v = 1'b0;
  logic e27 = 1'b1;
  logic e26 = 1'b1;
  logic [31:0] req_a = 32'h00000000;
  logic [31:0] req_d = 32'h00000000;
  logic [31:0] mem_d, wr_d, rd_d;
  logic [4:0] sel_n;
  logic [27:0] ext_a;
  logic [3:0] oe, w0;
  logic alt_fn, rd_v, miss, boot_done;
  logic [19:0] t_base [CSD_NUM_SEL];
  logic [19:0] t_mask [CSD_NUM_SEL];
  logic [1:0] t_pw [CSD_NUM_SEL];
  logic t_dr [CSD_NUM_SEL];
  logic t_v [CSD_NUM_SEL];
  logic t_e27, t_e26;
  logic [31:0] rs = 32'h0C15774A;
  csd_exp_s eq [$];
  logic [31:0] rq [$];
  csd_exp_s me;
  logic [31:0] r_msk, r_adr;
  int n_fail = 0;
  int check_count = 0;

  always #2 core_clk_i = ~core_clk_i;

  csd_top dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .boot_strap_i(strap),
    .cfg_we_i(cfg_we), .cfg_idx_i(cfg_idx), .cfg_base_i(cfg_base), .cfg_mask_i(cfg_mask),
    .cfg_port_width_field_i(cfg_pw), .cfg_dynamic_select_field_i(cfg_dr), .cfg_wait_i(cfg_wait),
    .cfg_select_valid_bit_i(cfg_v), .memcfg_we_i(memcfg_we), .memcfg_upper_addr27_enable_i(e27),
    .memcfg_upper_addr26_enable_i(e26), .req_valid_i(req_v), .req_wr_i(req_wr), .req_addr_i(req_a),
    .req_wdata_i(req_d), .data_i(mem_d), .select_or_row_strobe_n_o(sel_n), .ext_addr_o(ext_a),
    .upper_addr_alt_fn_o(alt_fn), .data_o(wr_d), .data_lane_oe_o(oe), .rd_valid_o(rd_v),
    .rd_data_o(rd_d), .miss_o(miss), .sel0_wait_o(w0), .boot_done_o(boot_done));
  csd_mem_model mem (.core_clk_i(core_clk_i), .select_or_row_strobe_n_i(sel_n),
    .ext_addr_i(ext_a), .data_i(wr_d), .data_lane_oe_i(oe), .data_o(mem_d));

  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : xs

  function automatic logic [31:0] lm(input logic [3:0] o);
    return {{8{o[3]}}, {8{o[2]}}, {8{o[1]}}, {8{o[0]}}};
  endfunction : lm

  function automatic csd_exp_s predict(input logic [31:0] a, input logic wr, input logic [31:0] wd);
    csd_exp_s e;
    int s;
    e = '{5'h1F, 28'h0, 4'h0, 32'h0, 32'h0, 1'b1};
    for (int i = CSD_NUM_SEL - 1; i >= 0; i--) begin
      if (t_v[i] && (a[31:12] & t_mask[i]) == (t_base[i] & t_mask[i])) begin
        s = (t_pw[i] == CSD_PW_16) ? 1 : (t_pw[i] == CSD_PW_8) ? 0 : 2;
        e.sel = ~(5'h01 << i);
        e.miss = 1'b0;
        e.addr = t_dr[i] ? 28'((a >> (s + CSD_COL_BITS)) << s) : 28'((a >> s) << s);
        e.oe = !wr ? 4'h0 : (s == 0) ? CSD_LANES_8 : (s == 1) ? CSD_LANES_16 : CSD_LANES_32;
        e.dat = wr ? wd << (32 - (8 << s)) : 32'h0;
        e.rd = (s == 2) ? wd : wd & ~(32'hFFFFFFFF << (8 << s));
      end
    end
    if (!(t_e27 && t_e26)) begin
      e.addr[27:26] = 2'h0;
    end
    return e;
  endfunction : predict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic drive(input logic rq, input logic cw, input logic mw);
    @(negedge core_clk_i);
    req_v = rq;
    cfg_we = cw;
    memcfg_we = mw;
  endtask : drive

  task automatic acc(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    csd_exp_s e;
    drive(1'b1, 1'b0, 1'b0);
    e = predict(a, wr, wd);
    req_wr = wr;
    req_a = a;
    req_d = wd;
    eq.push_back(e);
    if (!wr && !e.miss) rq.push_back(e.rd);
  endtask : acc

  task automatic wr_rd(input logic [31:0] a, input logic [31:0] wd);
    acc(1'b1, a, wd);
    if (!eq[$].miss) acc(1'b0, a, wd);
  endtask : wr_rd

  task automatic cfg(input int i, input logic [19:0] b, input logic [19:0] m,
      input logic [1:0] pw, input logic dr, input logic v);
    drive(1'b0, 1'b1, 1'b0);
    cfg_idx = 3'(i);
    {cfg_base, cfg_mask, cfg_pw, cfg_dr, cfg_v} = {b, m, pw, dr, v};
    cfg_wait = 4'(i + 5);
    if (i < CSD_NUM_SEL) {t_base[i], t_mask[i], t_pw[i], t_dr[i], t_v[i]} = {b, m, pw, dr, v};
  endtask : cfg

  task automatic memcfg(input logic a27, input logic a26);
    drive(1'b0, 1'b0, 1'b1);
    {e27, e26, t_e27, t_e26} = {a27, a26, a27, a26};
  endtask : memcfg

  task automatic rst(input logic [1:0] st);
    drive(1'b0, 1'b0, 1'b0);
    repeat (2) @(negedge core_clk_i);
    sys_rst_i = 1'b1;
    strap = st;
    repeat (3) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    for (int i = 0; i < CSD_NUM_SEL; i++) {t_base[i], t_mask[i], t_pw[i], t_dr[i], t_v[i]} = '0;
    t_v[0] = (st != CSD_BOOT_OFF);
    t_pw[0] = (st == CSD_BOOT_SRAM16) ? CSD_PW_16 : CSD_PW_32;
    t_dr[0] = (st == CSD_BOOT_DRAM32);
    t_e27 = (st != CSD_BOOT_SRAM16);
    t_e26 = t_e27;
    @(negedge core_clk_i);
    chk(32'(boot_done), 32'h1, "boot done");
    chk(32'(w0), (st == CSD_BOOT_OFF) ? 32'h0 : 32'(CSD_BOOT_WAIT), "boot wait");
    chk(32'(alt_fn), 32'(st == CSD_BOOT_SRAM16), "alternate");
  endtask : rst

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  always @(negedge core_clk_i) begin
    if (!sys_rst_i && (sel_n !== CSD_SEL_IDLE || miss !== 1'b0)) begin
      if (eq.size() == 0) begin
        chk(32'(sel_n), 32'h1F, "unexpected access");
      end else begin
        me = eq.pop_front();
        chk(32'(sel_n), 32'(me.sel), "select");
        chk(32'(miss), 32'(me.miss), "miss");
        chk(32'(oe), 32'(me.oe), "lanes");
        if (!me.miss) chk(32'(ext_a), 32'(me.addr), "address");
        chk(wr_d & lm(me.oe), me.dat, "write data");
      end
    end
    if (rd_v !== 1'b0) begin
      if (rq.size() == 0) chk(32'h1, 32'h0, "unexpected read");
      else chk(rd_d, rq.pop_front(), "read data");
    end
  end

  initial begin
    repeat (5000) @(posedge core_clk_i);
    n_fail++;
    $display("wrong value at %0t: watchdog expired", $time);
    conclude();
  end

  initial begin
    for (int st = 0; st < 4; st++) begin
      rst(2'(st));
      wr_rd(32'h0ABCDEF5 ^ st, xs());
    end
    $display("test boot done");
    memcfg(1'b1, 1'b1);
    cfg(0, 20'h00000, 20'h00000, CSD_PW_32, 1'b0, 1'b0);
    cfg(5, 20'h00000, 20'h00000, CSD_PW_32, 1'b0, 1'b1);
    cfg(1, 20'h02034, 20'hFF000, CSD_PW_8, 1'b0, 1'b1);
    cfg(2, 20'h10000, 20'hF3000, CSD_PW_16, 1'b0, 1'b1);
    cfg(3, 20'h20001, 20'hFFFFF, CSD_PW_32, 1'b1, 1'b1);
    cfg(4, 20'h02000, 20'hFF000, CSD_PW_32X, 1'b0, 1'b1);
    drive(1'b0, 1'b0, 1'b0);
    chk(32'(alt_fn), 32'h0, "alternate");
    chk(32'(w0), 32'h5, "select zero wait");
    wr_rd(32'h02FFFFFF, xs());
    wr_rd(32'h02000003, xs());
    wr_rd(32'h1CABC002, xs());
    wr_rd(32'h10000FFE, xs());
    wr_rd(32'h20001FFC, xs());
    wr_rd(32'h20002000, xs());
    wr_rd(32'h12000000, xs());
    cfg(1, 20'h02034, 20'hFF000, CSD_PW_8, 1'b0, 1'b0);
    wr_rd(32'h02000007, xs());
    memcfg(1'b1, 1'b0);
    wr_rd(32'h1CABC002, xs());
    $display("test windows done");
    for (int k = 0; k <= 16; k++) begin
      cfg(0, 20'h40000, 20'(20'hFFFFF << k), CSD_PW_32, 1'b0, 1'b1);
      acc(1'b1, 32'h40000000 + (32'h1 << (12 + k)) - 32'h1, xs());
      acc(1'b1, 32'h40000000 + (32'h1 << (12 + k)), xs());
    end
    $display("test masks done");
    for (int n = 0; n < 40; n++) begin
      if (n % 10 == 0) memcfg(rs[4], rs[5]);
      r_msk = {t_mask[n % 4 + 1], 12'h000};
      r_adr = (n % 8 == 7) ? xs() : (xs() & ~r_msk) | ({t_base[n % 4 + 1], 12'h000} & r_msk);
      wr_rd(r_adr, xs());
    end
    $display("test random done");
    drive(1'b0, 1'b0, 1'b0);
    repeat (4) @(negedge core_clk_i);
    chk(32'(eq.size() + rq.size()), 32'h0, "pending results");
    conclude();
  end
endmodule : testbench
`default_nettype wire
